// ### design/rsc_clock_watch.v
`timescale 1ns/1ps
`include "rsc_defines.vh"

module rsc_clock_watch #(
  parameter TIMEOUT_CYCLES = `RSC_MCD_CYCLES
) (
  input wire lf_clk_i,
  input wire rstn_i,
  input wire heartbeat_i,
  output reg lost_o
);

  // ----------------------------------------------------------------
  // crossings into the oscillator domain
  // ----------------------------------------------------------------
  reg rst_s1;
  reg rst_s2;
  reg hb_s1;
  reg hb_s2;
  reg hb_s3;
  reg [15:0] count;

  always @(posedge lf_clk_i) begin
    rst_s1 <= rstn_i;
    rst_s2 <= rst_s1;
    hb_s1 <= heartbeat_i;
    hb_s2 <= hb_s1;
    hb_s3 <= hb_s2;
  end

  // ----------------------------------------------------------------
  // one-shot: restarts on every heartbeat edge
  // ----------------------------------------------------------------
  always @(posedge lf_clk_i) begin
    if (!rst_s2) begin
      count <= 16'h0000;
      lost_o <= 1'b0;
    end else if (hb_s2 != hb_s3) begin
      count <= 16'h0000;
      lost_o <= 1'b0;
    end else if (count == TIMEOUT_CYCLES[15:0] - 16'h0001) begin
      lost_o <= 1'b1;
    end else begin
      count <= count + 16'h0001;
    end
  end

endmodule // rsc_clock_watch

// ### design/rsc_defines.vh
// Operation
// - monitor resets only when also selected
// - status bit shows live supply comparison
// - low six monitor bits ignore writes
// - low pin resets; pin flag set after
// - stopped clock beyond timeout forces reset
// - bit2 write enables detector; reads flag
// - comparator below input resets when enabled
// - internal resets other than power-on and the monitor never drive the pin
// - watchdog enabled, clock divided twelve, resets
// - watchdog flag reads one after timeout
// - address above code limit forces reset
// - security-blocked flash access forces fault reset
// - flash fault flag after flash reset
// - writing one forces reset; flag after
// - power flag set on power/monitor reset
// - power flag write selects monitor source
// - top cause bit reads zero always
// - other resets clear the power flag
// - power-on enables and selects monitor only
// - monitor drives pin low while tripped
`ifndef RSC_DEFINES_VH
`define RSC_DEFINES_VH

// ----------------------------------------------------------------
// register addresses on the special-function bus
// ----------------------------------------------------------------
`define RSC_ADDR_CAUSE 8'hef
`define RSC_ADDR_MONITOR 8'hff

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RSC_BIT_PIN 0
`define RSC_BIT_POR 1
`define RSC_BIT_MCD 2
`define RSC_BIT_WDT 3
`define RSC_BIT_SOFT 4
`define RSC_BIT_CMP 5
`define RSC_BIT_FLASH 6
`define RSC_BIT_MON_EN 7
`define RSC_BIT_SUPPLY_OK 6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RSC_CAUSE_POR 7'h02
`define RSC_SYNC_RST 4'h5

// ----------------------------------------------------------------
// limits and timing
// ----------------------------------------------------------------
`define RSC_CODE_LIMIT 16'h1dff
`define RSC_WDT_DIV 12
`define RSC_CLK_PERIOD_NS 8
`define RSC_LF_PERIOD_NS 100
`define RSC_MCD_TIMEOUT_NS 100000
`define RSC_MCD_CYCLES ((`RSC_MCD_TIMEOUT_NS + `RSC_LF_PERIOD_NS - 1) / `RSC_LF_PERIOD_NS)
`define RSC_RST_DELAY_NS 5000
`define RSC_RST_HOLD_CYCLES ((`RSC_RST_DELAY_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)
`define RSC_HB_BIT 4

`endif

// ### design/rsc_reset_controller.v
`timescale 1ns/1ps
`include "rsc_defines.vh"

module rsc_reset_controller #(
  parameter HOLD_CYCLES = `RSC_RST_HOLD_CYCLES,
  parameter MCD_CYCLES = `RSC_MCD_CYCLES,
  parameter [15:0] CODE_LIMIT = `RSC_CODE_LIMIT
) (
  input wire clock_i,
  input wire rstn_i,
  input wire lf_osc_i,
  input wire [7:0] sfr_addr_i,
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  input wire [7:0] sfr_wdata_i,
  output reg [7:0] sfr_rdata_o,
  input wire supply_ok_i,
  input wire comp_below_i,
  input wire rst_pin_i,
  output wire rst_pin_o,
  output wire rst_pin_oe_n_o,
  input wire wdt_timeout_i,
  input wire wdt_disable_i,
  output reg wdt_enable_o,
  output reg wdt_tick_o,
  input wire flash_wr_i,
  input wire psw_en_i,
  input wire [15:0] flash_wr_addr_i,
  input wire code_rd_i,
  input wire [15:0] code_rd_addr_i,
  input wire branch_i,
  input wire [15:0] branch_addr_i,
  input wire flash_blocked_i,
  output wire sys_reset_o
);

  localparam ST_RUN = 1'b0;
  localparam ST_HOLD = 1'b1;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg state;
  reg next_state;
  reg [15:0] hold_count;
  reg [15:0] next_hold_count;
  reg [6:0] cause;
  reg [6:0] next_cause;
  reg [6:0] flags;
  reg monitor_en;
  reg monitor_sel;
  reg mcd_en;
  reg comp_en;
  reg drive_pin;
  reg [2:0] drive_dly;
  reg [3:0] wdt_div;
  reg [`RSC_HB_BIT:0] heartbeat;
  wire clock_lost;
  wire [3:0] async_in;
  wire [3:0] sync_q;

  // ----------------------------------------------------------------
  // two-stage synchronisers for pins and the oscillator domain
  // ----------------------------------------------------------------
  assign async_in = {clock_lost, rst_pin_i, comp_below_i, supply_ok_i};

  // per-bit reset levels: supply ok and pin idle high, the rest low
  localparam [3:0] SYNC_RST = `RSC_SYNC_RST;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      reg s1;
      reg s2;
      always @(posedge clock_i) begin
        if (!rstn_i) begin
          s1 <= SYNC_RST[gi];
          s2 <= SYNC_RST[gi];
        end else begin
          s1 <= async_in[gi];
          s2 <= s1;
        end
      end
      assign sync_q[gi] = s2;
    end
  endgenerate

  wire supply_ok_s = sync_q[0];
  wire below_s = sync_q[1];
  wire pin_s = sync_q[2];
  wire lost_s = sync_q[3];

  // ----------------------------------------------------------------
  // clock loss one-shot on the independent oscillator
  // ----------------------------------------------------------------
  always @(posedge clock_i) begin
    if (!rstn_i)
      heartbeat <= {(`RSC_HB_BIT + 1){1'b0}};
    else
      heartbeat <= heartbeat + 1'b1;
  end

  rsc_clock_watch #(
    .TIMEOUT_CYCLES(MCD_CYCLES)
  ) u_watch (
    .lf_clk_i(lf_osc_i),
    .rstn_i(rstn_i),
    .heartbeat_i(heartbeat[`RSC_HB_BIT]),
    .lost_o(clock_lost)
  );

  // ----------------------------------------------------------------
  // reset requests
  // ----------------------------------------------------------------
  wire cause_sel = (sfr_addr_i == `RSC_ADDR_CAUSE);
  wire mon_sel = (sfr_addr_i == `RSC_ADDR_MONITOR);
  wire run = (state == ST_RUN);

  wire vdm_req = monitor_en & monitor_sel & ~supply_ok_s;
  wire pin_req = ~pin_s & ~drive_pin & ~(|drive_dly);
  wire mcd_req = mcd_en & lost_s;
  wire cmp_req = comp_en & below_s;
  wire wdt_req = wdt_enable_o & wdt_timeout_i & run;
  wire flash_req = run & ((flash_wr_i & psw_en_i & (flash_wr_addr_i > CODE_LIMIT)) |
                   (code_rd_i & (code_rd_addr_i > CODE_LIMIT)) |
                   (branch_i & (branch_addr_i > CODE_LIMIT)));
  wire fsec_req = run & flash_blocked_i;
  wire soft_req = run & sfr_wr_i & cause_sel & sfr_wdata_i[`RSC_BIT_SOFT];
  wire level_req = vdm_req | pin_req | mcd_req | cmp_req;
  wire any_req = level_req | wdt_req | flash_req | fsec_req | soft_req;

  // one source per reset, most fundamental first
  function [6:0] pick_cause;
    input vdm;
    input pin;
    input clock_loss_detector;
    input cmp;
    input wdt;
    input fls;
    input sft;
    begin
      pick_cause = 7'h00;
      if (vdm)
        pick_cause[`RSC_BIT_POR] = 1'b1;
      else if (pin)
        pick_cause[`RSC_BIT_PIN] = 1'b1;
      else if (clock_loss_detector)
        pick_cause[`RSC_BIT_MCD] = 1'b1;
      else if (cmp)
        pick_cause[`RSC_BIT_CMP] = 1'b1;
      else if (wdt)
        pick_cause[`RSC_BIT_WDT] = 1'b1;
      else if (fls)
        pick_cause[`RSC_BIT_FLASH] = 1'b1;
      else if (sft)
        pick_cause[`RSC_BIT_SOFT] = 1'b1;
    end
  endfunction

  // ----------------------------------------------------------------
  // reset sequencer
  // ----------------------------------------------------------------
  always @* begin
    next_state = state;
    next_hold_count = hold_count;
    next_cause = cause;
    case (state)
      ST_RUN: begin
        if (any_req) begin
          next_state = ST_HOLD;
          next_hold_count = HOLD_CYCLES[15:0] - 16'h0001;
          next_cause = pick_cause(vdm_req, pin_req, mcd_req, cmp_req, wdt_req,
                                  flash_req | fsec_req, soft_req);
        end
      end
      ST_HOLD: begin
        if (vdm_req)
          next_cause = pick_cause(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        if (level_req)
          next_hold_count = HOLD_CYCLES[15:0] - 16'h0001;
        else if (hold_count != 16'h0000)
          next_hold_count = hold_count - 16'h0001;
        else
          next_state = ST_RUN;
      end
      default: begin
        next_state = ST_HOLD;
        next_hold_count = HOLD_CYCLES[15:0] - 16'h0001;
        next_cause = `RSC_CAUSE_POR;
      end
    endcase
  end

  always @(posedge clock_i) begin
    if (!rstn_i) begin
      state <= ST_HOLD;
      hold_count <= HOLD_CYCLES[15:0] - 16'h0001;
      cause <= `RSC_CAUSE_POR;
      flags <= `RSC_CAUSE_POR;
    end else begin
      state <= next_state;
      hold_count <= next_hold_count;
      cause <= next_cause;
      if (state == ST_HOLD && next_state == ST_RUN)
        flags <= cause;
    end
  end

  assign sys_reset_o = (state == ST_HOLD) | (mcd_en & clock_lost);

  // ----------------------------------------------------------------
  // pin drive: only power-on and supply monitor resets pull it low
  // ----------------------------------------------------------------
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      drive_pin <= 1'b1;
      drive_dly <= 3'h7;
    end else begin
      drive_pin <= (next_state == ST_HOLD) & next_cause[`RSC_BIT_POR];
      drive_dly <= {drive_dly[1:0], drive_pin};
    end
  end

  assign rst_pin_o = 1'b0;
  assign rst_pin_oe_n_o = ~drive_pin;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      monitor_en <= 1'b1;
      monitor_sel <= 1'b1;
      mcd_en <= 1'b0;
      comp_en <= 1'b0;
    end else if (state == ST_RUN && any_req) begin
      mcd_en <= 1'b0;
      comp_en <= 1'b0;
    end else if (run && sfr_wr_i) begin
      if (mon_sel)
        monitor_en <= sfr_wdata_i[`RSC_BIT_MON_EN];
      if (cause_sel) begin
        monitor_sel <= sfr_wdata_i[`RSC_BIT_POR];
        mcd_en <= sfr_wdata_i[`RSC_BIT_MCD];
        comp_en <= sfr_wdata_i[`RSC_BIT_CMP];
      end
    end
  end

  // ----------------------------------------------------------------
  // watchdog enable and divide-by-twelve tick
  // ----------------------------------------------------------------
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      wdt_enable_o <= 1'b1;
      wdt_div <= 4'h0;
      wdt_tick_o <= 1'b0;
    end else if (state == ST_HOLD) begin
      wdt_enable_o <= 1'b1;
      wdt_div <= 4'h0;
      wdt_tick_o <= 1'b0;
    end else begin
      if (wdt_disable_i)
        wdt_enable_o <= 1'b0;
      if (wdt_div == `RSC_WDT_DIV - 1) begin
        wdt_div <= 4'h0;
        wdt_tick_o <= 1'b1;
      end else begin
        wdt_div <= wdt_div + 4'h1;
        wdt_tick_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
      if (cause_sel)
        sfr_rdata_o <= {1'b0, flags};
      else if (mon_sel)
        sfr_rdata_o <= {monitor_en, supply_ok_s, 6'h00};
      else
        sfr_rdata_o <= 8'h00;
    end
  end

endmodule // rsc_reset_controller

// ### dv/rsc_pin_circuit.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// external reset circuit with pull-up
// ----------------------------------------------------------------
module rsc_pin_circuit (
  input wire clock_i,
  input wire start_i,
  input wire [7:0] len_i,
  input wire dev_oe_n_i,
  input wire dev_val_i,
  output wire pin_o
);
  reg [7:0] cnt = 8'h00;
  always @(posedge clock_i) begin
    if (start_i) begin
      cnt <= len_i;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end
  end
  // pull-up wins unless somebody pulls the line down
  assign pin_o = (cnt != 8'h00) ? 1'b0 : (dev_oe_n_i ? 1'b1 : dev_val_i);
endmodule // rsc_pin_circuit

// ### dv/rsc_reset_controller_asserts.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module rsc_reset_controller_asserts #(
  parameter [15:0] CODE_LIMIT = 16'h1dff
) (
  input wire clock_i,
  input wire rstn_i,
  input wire [7:0] sfr_addr_i,
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  input wire [7:0] sfr_wdata_i,
  input wire [7:0] sfr_rdata_o,
  input wire supply_ok_i,
  input wire rst_pin_i,
  input wire rst_pin_oe_n_o,
  input wire wdt_timeout_i,
  input wire wdt_enable_o,
  input wire wdt_tick_o,
  input wire flash_wr_i,
  input wire psw_en_i,
  input wire [15:0] flash_wr_addr_i,
  input wire code_rd_i,
  input wire [15:0] code_rd_addr_i,
  input wire branch_i,
  input wire [15:0] branch_addr_i,
  input wire flash_blocked_i,
  input wire sys_reset_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  wire bad_addr = (flash_wr_i && psw_en_i && flash_wr_addr_i > CODE_LIMIT)
    || (code_rd_i && code_rd_addr_i > CODE_LIMIT) || (branch_i && branch_addr_i > CODE_LIMIT);
  sequence s_quiet11;
    !wdt_tick_o [*8] ##1 !wdt_tick_o [*3];
  endsequence
  sequence s_run11;
    (wdt_enable_o && !sys_reset_o) [*8] ##1 (wdt_enable_o && !sys_reset_o) [*3];
  endsequence
  a_soft_force: assert property (
    sfr_wr_i && sfr_addr_i == 8'hef && sfr_wdata_i[4] && !sys_reset_o |=> sys_reset_o
  ) else $error("soft write gave no reset");
  a_pulse_source: assert property (
    ((wdt_timeout_i && wdt_enable_o) || flash_blocked_i || bad_addr) && !sys_reset_o
    |=> sys_reset_o
  ) else $error("pulse source gave no reset");
  a_pin_enters: assert property (
    $fell(rst_pin_i) && rst_pin_oe_n_o && !sys_reset_o |-> ##[1:4] sys_reset_o
  ) else $error("low pin gave no reset");
  a_pin_untouched: assert property (
    $rose(sys_reset_o) && supply_ok_i |-> rst_pin_oe_n_o [*4]
  ) else $error("internal reset drove the pin");
  a_pin_in_reset: assert property (
    !rst_pin_oe_n_o |-> sys_reset_o || $past(sys_reset_o)
  ) else $error("pin driven outside reset");
  a_status_live: assert property (
    supply_ok_i [*4] ##0 (sfr_rd_i && sfr_addr_i == 8'hff) |=> sfr_rdata_o[6]
  ) else $error("supply status wrong");
  a_top_zero: assert property (
    sfr_rd_i && sfr_addr_i == 8'hef |=> !sfr_rdata_o[7]
  ) else $error("cause bit7 set");
  a_wdt_on: assert property (
    $fell(sys_reset_o) |-> wdt_enable_o
  ) else $error("watchdog off after reset");
  a_tick_gap: assert property (
    wdt_tick_o |=> s_quiet11
  ) else $error("watchdog tick too early");
  a_tick_period: assert property (
    wdt_tick_o ##1 s_run11 |=> wdt_tick_o
  ) else $error("watchdog tick missing");
endmodule // rsc_reset_controller_asserts

bind rsc_reset_controller rsc_reset_controller_asserts #(.CODE_LIMIT(CODE_LIMIT)) u_chk (
  .clock_i, .rstn_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o,
  .supply_ok_i, .rst_pin_i, .rst_pin_oe_n_o, .wdt_timeout_i, .wdt_enable_o, .wdt_tick_o,
  .flash_wr_i, .psw_en_i, .flash_wr_addr_i, .code_rd_i, .code_rd_addr_i, .branch_i,
  .branch_addr_i, .flash_blocked_i, .sys_reset_o
);

// ### dv/rsc_reset_controller_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module rsc_reset_controller_tb;
  reg clock_i = 0, rstn_i = 0, lf_osc_i = 0, clk_run = 1, pin_go = 0;
  reg sfr_wr_i = 0, sfr_rd_i = 0, supply_ok_i = 1, comp_below_i = 0, wdt_timeout_i = 0;
  reg wdt_disable_i = 0, flash_wr_i = 0, psw_en_i = 0, code_rd_i = 0, branch_i = 0;
  reg flash_blocked_i = 0;
  reg [7:0] sfr_addr_i = 0, sfr_wdata_i = 0, pin_len = 0, d;
  reg [15:0] flash_wr_addr_i = 0, code_rd_addr_i = 0, branch_addr_i = 0;
  reg [31:0] lfsr = 32'h242a3adf;
  wire [7:0] sfr_rdata_o;
  wire rst_pin_i, rst_pin_o, rst_pin_oe_n_o, wdt_enable_o, wdt_tick_o, sys_reset_o;
  int err_total = 0, checked = 0;
  initial forever #4 if (clk_run) clock_i = ~clock_i;
  initial forever #50 lf_osc_i = ~lf_osc_i;
  rsc_reset_controller #(.HOLD_CYCLES(4), .MCD_CYCLES(20)) uut (.clock_i, .rstn_i, .lf_osc_i,
    .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .supply_ok_i, .comp_below_i,
    .rst_pin_i, .rst_pin_o, .rst_pin_oe_n_o, .wdt_timeout_i, .wdt_disable_i, .wdt_enable_o,
    .wdt_tick_o, .flash_wr_i, .psw_en_i, .flash_wr_addr_i, .code_rd_i, .code_rd_addr_i,
    .branch_i, .branch_addr_i, .flash_blocked_i, .sys_reset_o);
  rsc_pin_circuit u_pin (.clock_i, .start_i(pin_go), .len_i(pin_len),
    .dev_oe_n_i(rst_pin_oe_n_o), .dev_val_i(rst_pin_o), .pin_o(rst_pin_i));
  // ----------------------------------------------------------------
  // reference model and bus tasks
  // ----------------------------------------------------------------
  function automatic [7:0] model(input int k);
    int pos[10] = '{4, 3, 6, 6, 6, 6, 5, 0, 2, 1};
    model = 8'h01 << pos[k];
  endfunction
  function automatic [31:0] rnd(input [31:0] s);
    rnd = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task test_done();
    if (err_total == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task wr(input [7:0] a, input [7:0] v);
    @(posedge clock_i);
    sfr_wr_i <= 1'b1;
    sfr_addr_i <= a;
    sfr_wdata_i <= v;
    @(posedge clock_i);
    sfr_wr_i <= 1'b0;
  endtask
  task rd(input [7:0] a);
    @(posedge clock_i);
    sfr_rd_i <= 1'b1;
    sfr_addr_i <= a;
    @(posedge clock_i);
    sfr_rd_i <= 1'b0;
    #1 d = sfr_rdata_o;
  endtask
  task wait_rst(input v);
    int n;
    n = 0;
    while (sys_reset_o !== v && n < 3000) begin
      @(posedge clock_i);
      n++;
    end
    `CHK(sys_reset_o, v)
  endtask
  task fire(input int k);
    lfsr = rnd(lfsr);
    case (k)
      0: wr(8'hef, 8'h12 | (lfsr[7:0] & 8'h80));
      6: wr(8'hef, 8'h22);
      8: wr(8'hef, 8'h06);
      9: wr(8'hef, 8'h02);
      default: ;
    endcase
    if (k == 8) begin
      clk_run = 0;
      #4000 `CHK(sys_reset_o, 1'b1)
      clk_run = 1;
    end
    @(posedge clock_i);
    wdt_timeout_i <= (k == 1);
    flash_wr_i <= (k == 2);
    psw_en_i <= (k == 2);
    flash_wr_addr_i <= 16'h1e00 + lfsr[8:0];
    code_rd_i <= (k == 3);
    code_rd_addr_i <= 16'h1e00;
    branch_i <= (k == 4);
    branch_addr_i <= 16'hffff;
    flash_blocked_i <= (k == 5);
    comp_below_i <= (k == 6);
    pin_go <= (k == 7);
    pin_len <= 8'd10 + lfsr[3:0];
    supply_ok_i <= (k != 9);
    @(posedge clock_i);
    {wdt_timeout_i, flash_wr_i, code_rd_i, branch_i, flash_blocked_i, pin_go} <= 6'h00;
    wait_rst(1);
    `CHK(rst_pin_oe_n_o, k != 9)
    comp_below_i <= 1'b0;
    supply_ok_i <= 1'b1;
    wait_rst(0);
    rd(8'hef);
    `CHK(d, model(k))
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clock_i);
    rstn_i <= 1'b1;
    wait_rst(0);
    rd(8'hef);
    `CHK(d, 8'h02)
    rd(8'hff);
    `CHK(d & 8'hc0, 8'hc0)
    lfsr = rnd(lfsr);
    rd({1'b0, lfsr[6:0]});
    `CHK(d, 8'h00)
    wr(8'hef, 8'h00);
    @(posedge clock_i);
    {flash_wr_i, code_rd_i, branch_i, supply_ok_i} <= 4'he;
    flash_wr_addr_i <= 16'h1e00;
    code_rd_addr_i <= 16'h1dff;
    branch_addr_i <= 16'h1dff;
    @(posedge clock_i);
    {flash_wr_i, code_rd_i, branch_i} <= 3'h0;
    repeat (6) @(posedge clock_i);
    `CHK(sys_reset_o, 1'b0)
    rd(8'hff);
    `CHK(d & 8'hc0, 8'h80)
    supply_ok_i <= 1'b1;
    wr(8'hff, 8'h3f);
    rd(8'hff);
    `CHK(d & 8'hc0, 8'h40)
    wr(8'hff, 8'h3f);
    @(posedge clock_i);
    wdt_disable_i <= 1'b1;
    @(posedge clock_i);
    wdt_disable_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    `CHK(wdt_enable_o, 1'b0)
    for (int k = 0; k < 10; k++) begin
      fire(k);
      if (k == 0) begin
        `CHK(wdt_enable_o, 1'b1)
        rd(8'hff);
        `CHK(d[7], 1'b0)
        wr(8'hff, 8'h80);
      end
    end
    test_done();
  end
  initial begin
    #400000;
    err_total++;
    test_done();
  end
endmodule // rsc_reset_controller_tb
